// ===== rtl/tac_pkg.sv
// tac_pkg: constants for the touch converter control block
// assumes a 200 MHz core clock and a 16-bit serial register port
package tac_pkg;
  localparam int CLK_MHZ = 200; // core clock rate
  // serial frame: command word then data word
  localparam int FRAME_BITS = 32;
  localparam int CMD_BITS = 16;
  localparam int CMD_RD_BIT = 15; // 1 = read
  localparam int CMD_PAGE_LSB = 11; // 4-bit page
  localparam int CMD_ADDR_LSB = 5; // 6-bit address
  localparam logic [3:0] PAGE_CTRL = 4'h1;
  localparam logic [5:0] ADDR_ADC_CTRL = 6'h00;
  localparam logic [5:0] ADDR_DAC_CTRL = 6'h02;
  localparam logic [15:0] RD_UNMAPPED = 16'hffff;
  // converter control word fields
  localparam int F_PEN = 15;
  localparam int F_STS = 14;
  localparam int F_FN_LSB = 10;
  localparam int F_RES_LSB = 8;
  localparam int F_AVG_LSB = 6;
  localparam int F_CLK_LSB = 4;
  localparam int F_SET_LSB = 1;
  localparam int F_DPD = 15; // dac power-down bit
  // reset values
  localparam logic [3:0] FN_RST = 4'h0;
  localparam logic [1:0] RES_RST = 2'h0;
  localparam logic [1:0] AVG_RST = 2'h0;
  localparam logic [1:0] CLK_RST = 2'h0;
  localparam logic [2:0] SET_RST = 3'h0;
  localparam logic DPD_RST = 1'b0;
  // resolution and clock codes
  localparam logic [1:0] RES_8 = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] CLK_8M = 2'h0;
  localparam logic [1:0] CLK_4M = 2'h1;
  localparam logic [1:0] CLK_2M = 2'h2;
  // settling delays in microseconds
  localparam int SET_US_1 = 100;
  localparam int SET_US_2 = 500;
  localparam int SET_US_3 = 1000;
  localparam int SET_US_4 = 5000;
  localparam int SET_US_5 = 10000;
  localparam int SET_US_6 = 50000;
  localparam int SET_US_7 = 100000;
  // result channels
  localparam logic [3:0] CH_X = 4'h0;
  localparam logic [3:0] CH_Y = 4'h1;
  localparam logic [3:0] CH_Z1 = 4'h2;
  localparam logic [3:0] CH_Z2 = 4'h3;
  localparam logic [3:0] CH_B1 = 4'h4;
  localparam logic [3:0] CH_B2 = 4'h5;
  localparam logic [3:0] CH_A1 = 4'h6;
  localparam logic [3:0] CH_A2 = 4'h7;
  localparam logic [3:0] CH_T1 = 4'h8;
  localparam logic [3:0] CH_T2 = 4'h9;
  typedef enum logic [1:0] {
    DRV_XX = 2'h1, DRV_YY = 2'h2, DRV_YX = 2'h3
  } tac_drv_t;
endpackage

// ===== rtl/tac_ctrl.sv
// tac_ctrl: converter control word, dac power control, scan sequencer
// assumes an analog converter on clk that answers conv_start with
// conv_done and right-justified conv_data; serial pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module tac_ctrl
  import tac_pkg::*;
#(
  parameter int SET_CYC_1 = SET_US_1 * CLK_MHZ,
  parameter int SET_CYC_2 = SET_US_2 * CLK_MHZ,
  parameter int SET_CYC_3 = SET_US_3 * CLK_MHZ,
  parameter int SET_CYC_4 = SET_US_4 * CLK_MHZ,
  parameter int SET_CYC_5 = SET_US_5 * CLK_MHZ,
  parameter int SET_CYC_6 = SET_US_6 * CLK_MHZ,
  parameter int SET_CYC_7 = SET_US_7 * CLK_MHZ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic pen_down,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output logic conv_start,
  output logic adc_power,
  output logic [3:0] conv_channel,
  output logic [1:0] conv_resolution,
  output logic [1:0] conv_clock,
  output logic result_we,
  output logic [3:0] result_channel,
  output logic [11:0] result_data,
  output logic [1:0] panel_drive,
  output logic data_ready_n,
  output logic dac_power_down
);

  // counter wide enough for the longest delay
  localparam int CW = 25;

  // refuse delays the counter cannot hold or zero-length ones
  if (SET_CYC_1 < 1 || SET_CYC_7 >= (1 << CW) || SET_CYC_1 > SET_CYC_7) begin : g_chk
    $error("tac_ctrl: settling counts out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_PEN, ST_SETTLE, ST_START, ST_CONV, ST_DRIVE
  } tac_state_t;

  // synchronisers: stage a is read only by stage b
  logic [3:0] sync_a_ff; // raw capture
  logic [3:0] sync_b_ff; // safe to use
  logic sclk_d_ff; // previous sclk for edges
  logic sclk_s, cs_n_s, mosi_s, pen_s;

  // serial port state
  logic [5:0] bit_cnt_ff; // bits seen this frame
  logic [15:0] rx_ff; // incoming shift
  logic [15:0] cmd_ff; // latched command word
  logic [15:0] tx_ff; // outgoing read data
  logic wr_pulse_ff; // one-cycle write strobe
  logic [15:0] wdata_ff; // data of that write
  logic [5:0] waddr_ff; // address of that write
  logic miso_ff, miso_oe_ff;

  // control fields
  logic pen_mode_ff;
  logic [3:0] fn_ff;
  logic [1:0] res_ff, avg_ff, clk_ff;
  logic [2:0] set_ff;
  logic dpd_ff;
  logic sts_ff; // 1 = not busy

  // sequencer
  tac_state_t st_ff;
  logic [CW-1:0] cnt_ff; // settling countdown
  logic [1:0] idx_ff; // position in channel list
  logic [4:0] nav_ff; // conversions done this channel
  logic [15:0] acc_ff; // averaging sum
  logic start_ff, we_ff, dav_n_ff, pwr_ff;
  logic [3:0] ch_ff, rch_ff;
  logic [11:0] rdata_ff;
  logic [1:0] drv_ff;

  // two flip-flops on every serial pin and the pen input before use
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a_ff <= 4'h2;
      sync_b_ff <= 4'h2;
      sclk_d_ff <= 1'b0;
    end else begin
      sync_a_ff <= {pen_down, spi_mosi, spi_cs_n, spi_sclk};
      sync_b_ff <= sync_a_ff;
      sclk_d_ff <= sync_b_ff[0];
    end
  end

  assign sclk_s = sync_b_ff[0];
  assign cs_n_s = sync_b_ff[1];
  assign mosi_s = sync_b_ff[2];
  assign pen_s = sync_b_ff[3];

  logic sclk_rise, sclk_fall;
  assign sclk_rise = sclk_s && !sclk_d_ff && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d_ff && !cs_n_s;

  // decoded command fields
  logic cmd_ok;
  assign cmd_ok = cmd_ff[CMD_PAGE_LSB +: 4] == PAGE_CTRL;

  // read value of an address; unmapped reads all ones
  function automatic logic [15:0] rd_val(input logic [15:0] c);
    logic [15:0] v;
    v = RD_UNMAPPED;
    if (c[CMD_PAGE_LSB +: 4] == PAGE_CTRL) begin
      if (c[CMD_ADDR_LSB +: 6] == ADDR_ADC_CTRL) begin
        v = {pen_s, sts_ff, fn_ff, res_ff, avg_ff, clk_ff, set_ff, 1'b0};
      end else if (c[CMD_ADDR_LSB +: 6] == ADDR_DAC_CTRL) begin
        v = {dpd_ff, 15'h0000};
      end
    end
    return v;
  endfunction

  // serial receive: mode 0, sample on rising edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff <= 6'h00;
      rx_ff <= 16'h0000;
      cmd_ff <= 16'h0000;
      wr_pulse_ff <= 1'b0;
      wdata_ff <= 16'h0000;
      waddr_ff <= 6'h00;
    end else begin
      wr_pulse_ff <= 1'b0;
      if (cs_n_s) begin
        // deselect drops a partial frame
        bit_cnt_ff <= 6'h00;
      end else if (sclk_rise && bit_cnt_ff < 6'(FRAME_BITS)) begin
        rx_ff <= {rx_ff[14:0], mosi_s};
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
        if (bit_cnt_ff == 6'(CMD_BITS - 1)) begin
          cmd_ff <= {rx_ff[14:0], mosi_s};
        end
        if (bit_cnt_ff == 6'(FRAME_BITS - 1) && !cmd_ff[CMD_RD_BIT] && cmd_ok) begin
          wr_pulse_ff <= 1'b1;
          wdata_ff <= {rx_ff[14:0], mosi_s};
          waddr_ff <= cmd_ff[CMD_ADDR_LSB +: 6];
        end
      end
    end
  end

  // serial transmit: shift on falling edge during data word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_ff <= 16'h0000;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= !cs_n_s;
      if (cs_n_s) begin
        miso_ff <= 1'b0;
      end else if (sclk_rise && bit_cnt_ff == 6'(CMD_BITS - 1)) begin
        // read data frozen at end of command word
        tx_ff <= rd_val({rx_ff[14:0], mosi_s});
      end else if (sclk_fall && bit_cnt_ff >= 6'(CMD_BITS)) begin
        miso_ff <= tx_ff[15];
        tx_ff <= {tx_ff[14:0], 1'b0};
      end
    end
  end

  logic wr_adc, wr_dac;
  assign wr_adc = wr_pulse_ff && waddr_ff == ADDR_ADC_CTRL;
  assign wr_dac = wr_pulse_ff && waddr_ff == ADDR_DAC_CTRL;

  // control word storage; bit zero is never stored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pen_mode_ff <= 1'b0;
      fn_ff <= FN_RST;
      res_ff <= RES_RST;
      avg_ff <= AVG_RST;
      clk_ff <= CLK_RST;
      set_ff <= SET_RST;
    end else if (wr_adc) begin
      pen_mode_ff <= wdata_ff[F_PEN];
      fn_ff <= wdata_ff[F_FN_LSB +: 4];
      res_ff <= wdata_ff[F_RES_LSB +: 2];
      avg_ff <= wdata_ff[F_AVG_LSB +: 2];
      clk_ff <= wdata_ff[F_CLK_LSB +: 2];
      set_ff <= wdata_ff[F_SET_LSB +: 3];
    end
  end

  // dac power-down bit drives dac_power_down directly
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dpd_ff <= DPD_RST;
    end else if (wr_dac) begin
      dpd_ff <= wdata_ff[F_DPD];
    end
  end

  // channel list per function: {last, channel}
  function automatic logic [4:0] chan_at(input logic [3:0] f, input logic [1:0] i);
    logic [4:0] r;
    r = {1'b1, CH_X};
    unique case (f)
      4'h1: r = (i == 2'h0) ? {1'b0, CH_X} : {1'b1, CH_Y};
      4'h2: begin
        unique case (i)
          2'h0: r = {1'b0, CH_X};
          2'h1: r = {1'b0, CH_Y};
          2'h2: r = {1'b0, CH_Z1};
          default: r = {1'b1, CH_Z2};
        endcase
      end
      4'h3: r = {1'b1, CH_X};
      4'h4: r = {1'b1, CH_Y};
      4'h5: r = (i == 2'h0) ? {1'b0, CH_Z1} : {1'b1, CH_Z2};
      4'h6: r = {1'b1, CH_B1};
      4'h7: r = {1'b1, CH_B2};
      4'h8: r = {1'b1, CH_A1};
      4'h9: r = {1'b1, CH_A2};
      4'ha: r = {1'b1, CH_T1};
      4'hb: begin
        unique case (i)
          2'h0: r = {1'b0, CH_B1};
          2'h1: r = {1'b0, CH_B2};
          2'h2: r = {1'b0, CH_A1};
          default: r = {1'b1, CH_A2};
        endcase
      end
      4'hc: r = {1'b1, CH_T2};
      default: r = {1'b1, CH_X};
    endcase
    return r;
  endfunction

  // settling count for the selected code
  function automatic logic [CW-1:0] set_cyc(input logic [2:0] s);
    logic [CW-1:0] c;
    c = '0;
    unique case (s)
      3'h0: c = '0;
      3'h1: c = CW'(SET_CYC_1);
      3'h2: c = CW'(SET_CYC_2);
      3'h3: c = CW'(SET_CYC_3);
      3'h4: c = CW'(SET_CYC_4);
      3'h5: c = CW'(SET_CYC_5);
      3'h6: c = CW'(SET_CYC_6);
      3'h7: c = CW'(SET_CYC_7);
    endcase
    return c;
  endfunction

  // conversions per channel and shift for the mean
  logic [4:0] nav_need;
  logic [2:0] nav_shift;
  always_comb begin
    unique case (avg_ff)
      2'h0: begin nav_need = 5'd1; nav_shift = 3'd0; end
      2'h1: begin nav_need = 5'd4; nav_shift = 3'd2; end
      2'h2: begin nav_need = 5'd8; nav_shift = 3'd3; end
      default: begin nav_need = 5'd16; nav_shift = 3'd4; end
    endcase
  end

  // write-time decode of the new function
  logic [3:0] wfn;
  logic touch_fn, scan_fn, drive_fn;
  assign wfn = wdata_ff[F_FN_LSB +: 4];
  assign touch_fn = wfn >= 4'h1 && wfn <= 4'h5;
  assign scan_fn = wfn == 4'h1 || wfn == 4'h2;
  assign drive_fn = wfn >= 4'hd;

  logic [4:0] cur;
  logic [15:0] acc_nxt;
  logic cont_fn;
  assign cur = chan_at(fn_ff, idx_ff);
  assign acc_nxt = acc_ff + {4'h0, conv_data};
  assign cont_fn = fn_ff == 4'h1 || fn_ff == 4'h2;

  // scan sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      idx_ff <= 2'h0;
      nav_ff <= 5'h00;
      acc_ff <= 16'h0000;
      start_ff <= 1'b0;
      we_ff <= 1'b0;
      rch_ff <= CH_X;
      rdata_ff <= 12'h000;
      sts_ff <= 1'b1;
      dav_n_ff <= 1'b1;
    end else begin
      start_ff <= 1'b0;
      we_ff <= 1'b0;
      if (wr_adc) begin
        // any converter control word write aborts the running function
        idx_ff <= 2'h0;
        nav_ff <= 5'h00;
        acc_ff <= 16'h0000;
        if (wdata_ff[F_STS] || wfn == 4'h0) begin
          st_ff <= ST_IDLE;
          sts_ff <= 1'b1;
        end else if (drive_fn) begin
          st_ff <= ST_DRIVE;
          sts_ff <= 1'b1;
        end else begin
          sts_ff <= 1'b0;
          dav_n_ff <= 1'b1;
          cnt_ff <= set_cyc(wdata_ff[F_SET_LSB +: 3]);
          if (scan_fn && wdata_ff[F_PEN]) begin
            st_ff <= ST_PEN;
          end else if (touch_fn) begin
            st_ff <= ST_SETTLE;
          end else begin
            st_ff <= ST_START;
          end
        end
      end else begin
        unique case (st_ff)
          ST_IDLE, ST_DRIVE: begin
            // nothing runs; drivers follow the state
          end
          ST_PEN: begin
            // touch-triggered mode waits for the pen
            if (pen_s) begin
              st_ff <= ST_SETTLE;
              cnt_ff <= set_cyc(set_ff);
            end
          end
          ST_SETTLE: begin
            if (cnt_ff == '0) begin
              st_ff <= ST_START;
            end else begin
              cnt_ff <= cnt_ff - CW'(1);
            end
          end
          ST_START: begin
            start_ff <= 1'b1;
            st_ff <= ST_CONV;
          end
          ST_CONV: begin
            if (conv_done) begin
              if (nav_ff + 5'h01 < nav_need) begin
                // more of the averaging set, stay busy
                nav_ff <= nav_ff + 5'h01;
                acc_ff <= acc_nxt;
                st_ff <= ST_START;
              end else begin
                we_ff <= 1'b1;
                rch_ff <= cur[3:0];
                rdata_ff <= 12'(acc_nxt >> nav_shift);
                nav_ff <= 5'h00;
                acc_ff <= 16'h0000;
                if (!cur[4]) begin
                  idx_ff <= idx_ff + 2'h1;
                  st_ff <= ST_START;
                end else if (cont_fn && pen_s) begin
                  // scan repeats while the pen stays down
                  idx_ff <= 2'h0;
                  st_ff <= ST_START;
                  dav_n_ff <= 1'b0;
                end else begin
                  idx_ff <= 2'h0;
                  st_ff <= ST_IDLE;
                  sts_ff <= 1'b1;
                  dav_n_ff <= 1'b0;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // converter set-up outputs; bad fast rates fall to 2 MHz
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_ff <= CH_X;
      pwr_ff <= 1'b0;
      drv_ff <= 2'h0;
      conv_resolution <= RES_RST;
      conv_clock <= CLK_2M;
    end else begin
      ch_ff <= cur[3:0];
      // stop powers the converter down at once
      pwr_ff <= st_ff == ST_START || st_ff == ST_CONV || st_ff == ST_SETTLE;
      drv_ff <= st_ff == ST_DRIVE ? fn_ff[1:0] : 2'h0;
      conv_resolution <= res_ff;
      if ((clk_ff == CLK_8M && res_ff != RES_8) || (clk_ff == CLK_4M && res_ff != RES_10)) begin
        conv_clock <= CLK_2M;
      end else begin
        conv_clock <= clk_ff;
      end
    end
  end

  assign spi_miso = miso_ff;
  assign spi_miso_oe = miso_oe_ff;
  assign conv_start = start_ff;
  assign adc_power = pwr_ff;
  assign conv_channel = ch_ff;
  assign result_we = we_ff;
  assign result_channel = rch_ff;
  assign result_data = rdata_ff;
  assign panel_drive = drv_ff;
  assign data_ready_n = dav_n_ff;
  assign dac_power_down = dpd_ff;

endmodule
`default_nettype wire

// ===== tb/tac_ctrl_chk.sv
// tac_ctrl_chk: port assertions for the converter control block
// assumes binding onto tac_ctrl, single clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module tac_ctrl_chk
  import tac_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic pen_down,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  input wire logic conv_start,
  input wire logic adc_power,
  input wire logic [3:0] conv_channel,
  input wire logic [1:0] conv_resolution,
  input wire logic [1:0] conv_clock,
  input wire logic result_we,
  input wire logic [3:0] result_channel,
  input wire logic [11:0] result_data,
  input wire logic [1:0] panel_drive,
  input wire logic data_ready_n,
  input wire logic dac_power_down
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // strobes last one cycle only
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  store_pulse_a: assert property (result_we |=> !result_we)
    else $error("result store longer than one cycle");
  // a store always follows a finished conversion
  store_done_a: assert property (result_we |-> $past(conv_done))
    else $error("result stored without a finished conversion");
  store_chan_a: assert property (result_we |-> result_channel == $past(conv_channel))
    else $error("result stored to the wrong channel");
  // fast rates only with the matching low resolution
  fast_clock_a: assert property (conv_clock == CLK_8M |-> conv_resolution == RES_8)
    else $error("fast conversion clock with wrong resolution");
  mid_clock_a: assert property (conv_clock == CLK_4M |-> conv_resolution == RES_10)
    else $error("middle conversion clock with wrong resolution");
  // ready only drops when the last result lands
  ready_fall_a: assert property ($fell(data_ready_n) |-> result_we)
    else $error("data ready without a stored result");
  // non-repeating channels convert while busy and powered
  busy_conv_a: assert property (conv_start && conv_channel >= CH_B1 |-> data_ready_n && adc_power)
    else $error("conversion while idle or powered down");
  // a held panel drive never converts
  drive_idle_a: assert property (panel_drive != 2'h0 && $past(panel_drive) != 2'h0
    |-> !conv_start && !result_we)
    else $error("conversion during panel drive");
  // reply driver enable follows the select through two syncs and a register
  oe_follow_a: assert property (spi_miso_oe == !$past(spi_cs_n, 3))
    else $error("reply enable does not follow the frame select");
  cover property (conv_start);
  cover property (result_we && result_channel == CH_T2);
  cover property (panel_drive == DRV_YX);
  cover property ($fell(adc_power));
endmodule
bind tac_ctrl tac_ctrl_chk u_tac_ctrl_chk (.clk, .arst_n, .spi_sclk, .spi_cs_n, .spi_mosi,
  .spi_miso, .spi_miso_oe, .pen_down, .conv_done, .conv_data, .conv_start, .adc_power,
  .conv_channel, .conv_resolution, .conv_clock, .result_we, .result_channel, .result_data,
  .panel_drive, .data_ready_n, .dac_power_down);
`default_nettype wire

// ===== tb/tac_host.sv
// tac_host: serial host model, 32-bit frames, mode 0, msb first
// assumes the core clock; sclk half period is 16 core cycles
`timescale 1ns/1ps
`default_nettype none
module tac_host (
  input wire logic clk,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // idle: sclk low, frame deselected
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // one frame; sclk stands still outside it
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] bits;
    bits = {cmd, wd};
    rd = 16'h0000;
    @(posedge clk);
    spi_cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      spi_mosi <= bits[i];
      repeat (16) @(posedge clk);
      spi_sclk <= 1'b1;
      // reply bits taken on the rising edge
      if (i < 16) rd[i] = spi_miso;
      repeat (16) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (16) @(posedge clk);
    spi_cs_n <= 1'b1;
    // released data line must not look like a held bit
    spi_mosi <= ~bits[0];
    repeat (32) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/tac_ctrl_test.sv
// tac_ctrl_test: random and corner scenarios for the control block
// assumes tac_host for the serial side; converter stand-in lives here
`timescale 1ns/1ps
`default_nettype none
module tac_ctrl_test;
  import tac_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, pen_down = 1'b0, conv_done = 1'b0, wr_go = 1'b0;
  logic [11:0] conv_data = 12'h000;
  wire logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, conv_start, adc_power;
  wire logic result_we, data_ready_n, dac_power_down;
  wire logic [3:0] conv_channel, result_channel;
  wire logic [1:0] conv_resolution, conv_clock, panel_drive;
  wire logic [11:0] result_data;
  int n_errors = 0, n_checks = 0, pend = 0, cnt = 0, nres = 0;
  logic [31:0] rnd = 32'h21f3;
  logic [15:0] sum = 16'h0000, qch = 16'hffff;
  logic [3:0] cur_fn = 4'h0, nfn = 4'h0;
  logic scan_done = 1'b0; // a whole channel list has landed in this run
  logic [1:0] cur_avg = 2'h0, navg = 2'h0;
  // expected channels per function code, top nibble first, f = end
  logic [15:0] chan_tab [16] = '{16'hffff, 16'h01ff, 16'h0123, 16'h0fff, 16'h1fff, 16'h23ff,
    16'h4fff, 16'h5fff, 16'h6fff, 16'h7fff, 16'h8fff, 16'h4567, 16'h9fff, 16'hffff, 16'hffff,
    16'hffff};
  always #2.5 clk = ~clk;
  // short settle counts keep the run brief; codes 6 and 7 keep their long defaults
  tac_ctrl #(.SET_CYC_1(10), .SET_CYC_2(20), .SET_CYC_3(30), .SET_CYC_4(40), .SET_CYC_5(50))
    u_tac_ctrl (.clk, .arst_n, .spi_sclk, .spi_cs_n,
    .spi_mosi, .spi_miso, .spi_miso_oe, .pen_down, .conv_done, .conv_data, .conv_start,
    .adc_power, .conv_channel, .conv_resolution, .conv_clock, .result_we, .result_channel,
    .result_data, .panel_drive, .data_ready_n, .dac_power_down);
  tac_host u_tac_host (.clk, .spi_miso, .spi_sclk, .spi_cs_n, .spi_mosi);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // shift of the averaging mean: 1, 4, 8, 16 samples
  function automatic int shamt(input logic [1:0] a);
    return (a == 2'h0) ? 0 : int'(a) + 1;
  endfunction
  function automatic logic [1:0] exp_clk(input logic [1:0] c, input logic [1:0] r);
    if ((c == CLK_8M && r != RES_8) || (c == CLK_4M && r != RES_10)) return CLK_2M;
    return c;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] v;
    // expectations switch when the frame opens; a stop means nothing more
    nfn = d[F_STS] ? 4'h0 : d[13:10];
    navg = d[7:6];
    wr_go = (a == ADDR_ADC_CTRL);
    u_tac_host.xfer({1'b0, PAGE_CTRL, a, 5'h00}, d, v);
  endtask
  task automatic rd(input logic [3:0] pg, input logic [5:0] a, output logic [15:0] v);
    u_tac_host.xfer({1'b1, pg, a, 5'h00}, 16'h0000, v);
  endtask
  // bounded wait for the end of a run or for a result count
  task automatic wait_for(input int want);
    int k;
    k = 0;
    while ((want < 0 ? data_ready_n !== 1'b0 : nres < want) && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (k == 4000) begin
      $display("MISMATCH wait expected done seen timeout");
      n_errors++;
      stop_test();
    end
    repeat (2) @(posedge clk);
  endtask
  // converter stand-in; it pauses while a frame is open
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (result_we) begin
      // repeating scans refill their channel list
      if (qch[15:12] == 4'hf && (cur_fn == 4'h1 || cur_fn == 4'h2)) qch = chan_tab[cur_fn];
      nres++;
      chk("channel", {12'h000, qch[15:12]}, {12'h000, result_channel});
      chk("mean", 16'(sum >> shamt(cur_avg)), {4'h0, result_data});
      chk("set size", 16'(1 << shamt(cur_avg)), 16'(cnt));
      qch = {qch[11:0], 4'hf};
      // ready stays low once a whole list has landed, repeats included
      if (qch[15:12] == 4'hf) scan_done = 1'b1;
      chk("ready", {15'h0000, !scan_done}, {15'h0000, data_ready_n});
      sum = 16'h0000;
      cnt = 0;
    end
    if (wr_go && !spi_cs_n) begin
      wr_go = 1'b0;
      cur_fn = nfn;
      cur_avg = navg;
      qch = chan_tab[nfn];
      scan_done = 1'b0;
      sum = 16'h0000;
      cnt = 0;
    end
    if (conv_start) pend = 3 + int'(rnd[1:0]);
    // a pending write freezes conversions so no old result lands after the switch
    else if (pend > 0 && spi_cs_n && !wr_go) begin
      pend--;
      if (pend == 0) begin
        rnd = lfsr(rnd);
        conv_done <= 1'b1;
        conv_data <= rnd[11:0];
        sum = sum + 16'(rnd[11:0]);
        cnt++;
      end
    end
  end
  initial begin
    logic [15:0] d, v;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values and unmapped places
    rd(PAGE_CTRL, ADDR_ADC_CTRL, v);
    chk("ctrl reset", 16'h4000, v);
    rd(PAGE_CTRL, 6'h01, v);
    chk("unmapped", RD_UNMAPPED, v);
    $display("test reset done");
    // field readback, fast clock corners first
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      d = {rnd[15], 5'h00, rnd[9:0]};
      if (i < 3) d[9:4] = (i == 0) ? 6'h10 : (i == 1) ? 6'h21 : 6'h00;
      wr(ADDR_ADC_CTRL, d);
      rd(PAGE_CTRL, ADDR_ADC_CTRL, v);
      chk("fields", {pen_down, 1'b1, d[13:1], 1'b0}, v);
      chk("clock", {14'h0000, exp_clk(d[5:4], d[9:8])}, {14'h0000, conv_clock});
      chk("resolution", {14'h0000, d[9:8]}, {14'h0000, conv_resolution});
    end
    $display("test readback done");
    // dac power bit, with a refused write between
    wr(ADDR_DAC_CTRL, 16'hffff);
    rd(PAGE_CTRL, ADDR_DAC_CTRL, v);
    chk("dac read", 16'h8000, v);
    u_tac_host.xfer({1'b0, 4'h2, ADDR_DAC_CTRL, 5'h00}, 16'h0000, v);
    chk("dac off", 16'h0001, {15'h0000, dac_power_down});
    wr(ADDR_DAC_CTRL, 16'h0000);
    chk("dac on", 16'h0000, {15'h0000, dac_power_down});
    $display("test dac done");
    // every converting function, every averaging code
    for (int f = 1; f <= 12; f++) begin
      rnd = lfsr(rnd);
      d = {2'b00, 4'(f), rnd[9:8], 2'(f), rnd[5:1], 1'b0};
      // settle codes 6 and 7 use the long default counts
      if (d[3:2] == 2'b11) d[3] = 1'b0;
      wr(ADDR_ADC_CTRL, d);
      wait_for(-1);
      chk("left", 16'h000f, {12'h000, qch[15:12]});
      rd(PAGE_CTRL, ADDR_ADC_CTRL, v);
      chk("done status", {2'b01, d[13:0]}, v);
    end
    $display("test functions done");
    // panel drive codes convert nothing
    for (int f = 13; f <= 15; f++) begin
      wr(ADDR_ADC_CTRL, {2'b00, 4'(f), 10'h000});
      repeat (8) @(posedge clk);
      chk("drive", {14'h0000, 2'(f)}, {14'h0000, panel_drive});
    end
    $display("test drive done");
    // touch-triggered repeating scan, then stop
    pen_down <= 1'b1;
    wr(ADDR_ADC_CTRL, 16'h8406);
    wait_for(nres + 6);
    rd(PAGE_CTRL, ADDR_ADC_CTRL, v);
    chk("touched busy", 16'h8000, v & 16'hc000);
    wr(ADDR_ADC_CTRL, 16'h4400);
    chk("stopped", 16'h0000, {15'h0000, adc_power});
    repeat (200) @(posedge clk);
    pen_down <= 1'b0;
    $display("test touch done");
    // abort a long port scan by a new function
    wr(ADDR_ADC_CTRL, 16'h2cc0);
    wait_for(nres + 1);
    wr(ADDR_ADC_CTRL, 16'h1800);
    wait_for(-1);
    chk("abort left", 16'h000f, {12'h000, qch[15:12]});
    $display("test abort done");
    stop_test();
  end
endmodule
`default_nettype wire
